// ### srpc_pkg.sv
// package for the refresh / power / command logic of a four-bank sdram
// assumes a single device clock; no software registers
package srpc_pkg;
  // command strobe encoding {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  // refresh rows and timing
  localparam int ROW_BITS = 13;
  localparam int REFRESH_ROWS = 8192;
  localparam int REFRESH_PERIOD_MS = 64;
  localparam int CLOCK_MHZ = 100;
  // self refresh interval per row in ns: 64 ms / 8192 rows, rounded down
  localparam int SELF_INTERVAL_NS = (REFRESH_PERIOD_MS * 1000000) / REFRESH_ROWS;
  localparam int SELF_INTERVAL_CYC = (SELF_INTERVAL_NS * CLOCK_MHZ) / 1000;
  localparam int LAT_BITS = 2;
  localparam logic [1:0] LAT_RESET = 2'h2;
  typedef enum logic [1:0] {
    SRPC_RUN = 2'b00,
    SRPC_SUSPEND = 2'b01,
    SRPC_POWER_DOWN = 2'b10,
    SRPC_SELF_REFRESH = 2'b11
  } srpc_state_e;
endpackage

// ### srpc_command_logic.sv
// command handling for refresh, power-down, clock suspend, burst stop and data mask
// assumes controller drives strobes on the falling edge of i_clock, inputs synchronous
//
// What this block does
// - a selected no-operation command changes nothing inside the device
// - burst stop ends a read or write burst lacking auto precharge
// - after burst stop in a read, data keeps flowing for read latency cycles
// - chip select high disables the decoder; strobes and address ignored
// - auto refresh uses the internal row counter, never the address lines
// - every auto refresh advances the refresh row counter by one
// - self refresh entry with clock enable low; then only clock enable matters
// - clock enable low during a burst suspends the clock and freezes state
// - clock enable low with banks idle enters power-down, buffers off
// - clock resumes the cycle after clock enable returns high
// - power-down exit re-enables buffers; next command a cycle later
// - during writes the mask input blocks writing of that word
// - during reads the mask low drives data, mask high floats outputs
`timescale 1ns/1ps
`default_nettype none
module srpc_command_logic
  import srpc_pkg::*;
#(
  parameter int SELF_CYCLES = SELF_INTERVAL_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic i_dqm,
  input wire logic i_all_banks_idle,
  input wire logic i_read_burst,
  input wire logic i_write_burst,
  input wire logic i_auto_precharge,
  input wire logic [LAT_BITS-1:0] i_read_latency,
  output logic o_internal_clk_en,
  output logic o_buffers_on,
  output logic o_self_refresh,
  output logic o_refresh_strobe,
  output logic [ROW_BITS-1:0] o_refresh_row,
  output logic o_burst_stop,
  output logic o_read_drain,
  output logic o_write_enable,
  output logic o_dq_oe
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // strobe pattern match, shared by the command decodes
  function automatic logic code_is(
    input logic [2:0] code,
    input logic [2:0] want
  );
    return (code == want);
  endfunction

  // either of two activity flags
  function automatic logic any_of(
    input logic a,
    input logic b
  );
    return a || b;
  endfunction

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic [2:0] cmd;
  logic selected;
  logic cke_prev_ff;
  logic taken;
  logic cmd_refresh;
  logic cmd_self_entry;
  logic cmd_stop;
  logic burst_active;
  srpc_state_e state_ff;
  srpc_state_e nxt_state;
  logic running;

  assign cmd = {i_ras_n, i_cas_n, i_we_n};
  assign running = (state_ff == SRPC_RUN);
  assign burst_active = any_of(i_read_burst, i_write_burst);
  // deselect masks every strobe
  assign selected = !i_cs_n && running;
  // a command counts only if clock enable was high the cycle before
  assign taken = selected && cke_prev_ff;
  // no-operation and unlisted codes decode to nothing here
  assign cmd_refresh = taken && i_cke && code_is(cmd, CMD_REFRESH);
  assign cmd_self_entry = taken && !i_cke && code_is(cmd, CMD_REFRESH);
  assign cmd_stop = taken && code_is(cmd, CMD_BURST_STOP)
    && burst_active && !i_auto_precharge;

  // ****************************************************************
  // clock enable history
  // ****************************************************************
  // reset treats clock enable as high so the first command is taken
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_prev_ff <= 1'b1;
    end else begin
      cke_prev_ff <= i_cke;
    end
  end

  // ****************************************************************
  // power state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SRPC_RUN: begin
        if (cmd_self_entry) begin
          nxt_state = SRPC_SELF_REFRESH;
        end else if (cke_prev_ff && !i_cke) begin
          if (burst_active) begin
            nxt_state = SRPC_SUSPEND;
          end else if (i_all_banks_idle) begin
            nxt_state = SRPC_POWER_DOWN;
          end else begin
            nxt_state = SRPC_SUSPEND;
          end
        end
      end
      SRPC_SUSPEND: begin
        if (i_cke) begin
          nxt_state = SRPC_RUN;
        end
      end
      SRPC_POWER_DOWN: begin
        if (i_cke) begin
          nxt_state = SRPC_RUN;
        end
      end
      SRPC_SELF_REFRESH: begin
        if (i_cke) begin
          nxt_state = SRPC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= SRPC_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // clock, buffer and self refresh outputs
  // ****************************************************************
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_internal_clk_en <= 1'b1;
    end else begin
      o_internal_clk_en <= (nxt_state == SRPC_RUN);
    end
  end

  // power-down and self refresh both switch the pin buffers off
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_buffers_on <= 1'b1;
    end else begin
      o_buffers_on <= (nxt_state != SRPC_POWER_DOWN)
        && (nxt_state != SRPC_SELF_REFRESH);
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_self_refresh <= 1'b0;
    end else begin
      o_self_refresh <= (nxt_state == SRPC_SELF_REFRESH);
    end
  end

  // ****************************************************************
  // self refresh timer
  // ****************************************************************
  // self refresh paces its own rows; no strobe from outside is needed
  logic [31:0] self_timer_ff;
  logic self_tick;
  assign self_tick = (state_ff == SRPC_SELF_REFRESH)
    && (self_timer_ff == 32'h0);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      self_timer_ff <= 32'h0;
    end else if (state_ff != SRPC_SELF_REFRESH) begin
      self_timer_ff <= 32'(SELF_CYCLES - 1);
    end else if (self_tick) begin
      self_timer_ff <= 32'(SELF_CYCLES - 1);
    end else begin
      self_timer_ff <= self_timer_ff - 32'h1;
    end
  end

  // ****************************************************************
  // refresh row counter
  // ****************************************************************
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_refresh_strobe <= 1'b0;
    end else begin
      o_refresh_strobe <= cmd_refresh || self_tick;
    end
  end

  // the row wraps once every row has been refreshed
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_refresh_row <= '0;
    end else if (cmd_refresh || self_tick) begin
      o_refresh_row <= o_refresh_row + ROW_BITS'(1);
    end
  end

  // ****************************************************************
  // burst stop
  // ****************************************************************
  // nothing is stopped while the internal clock is masked
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_burst_stop <= 1'b0;
    end else if (running) begin
      o_burst_stop <= cmd_stop;
    end else begin
      o_burst_stop <= 1'b0;
    end
  end

  // ****************************************************************
  // read drain
  // ****************************************************************
  // a suspended clock freezes the count so read data resumes in step
  logic [LAT_BITS-1:0] drain_ff;
  logic drain_start;

  assign drain_start = cmd_stop && i_read_burst;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drain_ff <= '0;
    end else if (running) begin
      if (drain_start) begin
        drain_ff <= i_read_latency;
      end else if (drain_ff != '0) begin
        drain_ff <= drain_ff - LAT_BITS'(1);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read_drain <= 1'b0;
    end else if (running) begin
      if (drain_start) begin
        o_read_drain <= 1'b1;
      end else if (drain_ff != '0) begin
        o_read_drain <= (drain_ff != LAT_BITS'(1));
      end else begin
        o_read_drain <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // write data mask
  // ****************************************************************
  // a masked word never reaches the array
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_write_enable <= 1'b0;
    end else begin
      o_write_enable <= running && i_write_burst && !i_dqm;
    end
  end

  // ****************************************************************
  // read output enable
  // ****************************************************************
  // power-down turns the output buffers off even inside a read
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dq_oe <= 1'b0;
    end else begin
      o_dq_oe <= o_buffers_on && any_of(i_read_burst, o_read_drain) && !i_dqm;
    end
  end

endmodule
`default_nettype wire

// ### srpc_chk_sva.sv
// checker for the sdram command logic ports
// assumes it is bound into srpc_command_logic
`timescale 1ns/1ps
`default_nettype none
// ******
// checker
// ******
module srpc_chk
  import srpc_pkg::*;
#(
  parameter int SELF_CYCLES = SELF_INTERVAL_CYC
) (
  input wire logic i_clock, i_sys_rst, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqm,
  input wire logic i_all_banks_idle, i_read_burst, i_write_burst, i_auto_precharge,
  input wire logic [LAT_BITS-1:0] i_read_latency,
  input wire logic o_internal_clk_en, o_buffers_on, o_self_refresh, o_refresh_strobe,
  input wire logic [ROW_BITS-1:0] o_refresh_row,
  input wire logic o_burst_stop, o_read_drain, o_write_enable, o_dq_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic run = o_internal_clk_en && o_buffers_on && !o_self_refresh;
  wire logic [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
  wire logic stp = run && i_cke && !i_cs_n && cmd == CMD_BURST_STOP && i_read_burst;
  sequence drain2_s; o_read_drain [*2] ##1 !o_read_drain; endsequence
  sequence drain3_s; o_read_drain [*3] ##1 !o_read_drain; endsequence
  refr_pulse_a: assert property (
    run && !i_cs_n && cmd == CMD_REFRESH && i_cke && $past(i_cke) |=> o_refresh_strobe)
    else $error("refresh not taken");
  row_step_a: assert property (
    o_refresh_strobe |-> o_refresh_row == $past(o_refresh_row) + 13'h1)
    else $error("row not advanced");
  quiet_cmd_a: assert property (
    run && i_cke && (i_cs_n || cmd == CMD_NOP) |=> !o_refresh_strobe && !o_burst_stop)
    else $error("idle command acted");
  stop_ap_a: assert property (
    stp && i_auto_precharge |=> !o_burst_stop) else $error("stop with precharge");
  drain_two_a: assert property (
    stp && !i_auto_precharge && i_read_latency == 2'h2 |=> drain2_s) else $error("drain 2");
  drain_three_a: assert property (
    stp && !i_auto_precharge && i_read_latency == 2'h3 |=> drain3_s) else $error("drain 3");
  self_entry_a: assert property (
    run && !i_cs_n && cmd == CMD_REFRESH && !i_cke && $past(i_cke) |=> o_self_refresh)
    else $error("self refresh not entered");
  pd_entry_a: assert property (
    run && !i_cke && i_cs_n && i_all_banks_idle && !i_read_burst && !i_write_burst
    |=> !o_internal_clk_en && !o_buffers_on) else $error("power-down not entered");
  suspend_a: assert property (
    run && !i_cke && i_cs_n && i_read_burst |=> !o_internal_clk_en && o_buffers_on)
    else $error("suspend not entered");
  wake_a: assert property (
    !o_internal_clk_en && !o_self_refresh && i_cke |=> o_internal_clk_en && o_buffers_on)
    else $error("no wake");
  self_exit_a: assert property (
    o_self_refresh && i_cke |=> !o_self_refresh && o_internal_clk_en && o_buffers_on)
    else $error("self refresh not left");
  write_mask_a: assert property (
    i_write_burst && i_dqm |=> !o_write_enable) else $error("masked word written");
  out_mask_a: assert property (
    i_read_burst && i_dqm |=> !o_dq_oe) else $error("masked output driven");
endmodule
`default_nettype wire

// ### srpc_ctrl_model.sv
// controller model driving command strobes and clock enable
// assumes the bench calls issue once per command
`timescale 1ns/1ps
`default_nettype none
// ******
// controller
// ******
module srpc_ctrl_model
  import srpc_pkg::*;
(
  input wire logic i_clock,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n
);
  initial {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = {2'b11, CMD_NOP};
  // one command, then selected no-operation with clock enable kept
  task automatic issue(input logic cs_n, input logic [2:0] cmd, input logic cke);
    @(negedge i_clock);
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = {cke, cs_n, cmd};
    @(negedge i_clock);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = {1'b0, CMD_NOP};
  endtask
endmodule
`default_nettype wire

// ### srpc_command_logic_bench.sv
// bench for the sdram command logic
// assumes srpc_pkg, srpc_ctrl_model and srpc_chk compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, g); mismatches++; end end
// ******
// bench
// ******
module srpc_command_logic_bench;
  import srpc_pkg::*;
  logic i_clock = 0, i_sys_rst = 1, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqm = 0;
  logic i_all_banks_idle = 1, i_read_burst = 0, i_write_burst = 0, i_auto_precharge = 0;
  logic [LAT_BITS-1:0] i_read_latency = LAT_RESET;
  logic o_internal_clk_en, o_buffers_on, o_self_refresh, o_refresh_strobe, o_burst_stop;
  logic o_read_drain, o_write_enable, o_dq_oe;
  logic [ROW_BITS-1:0] o_refresh_row;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #5 i_clock = ~i_clock;
  srpc_ctrl_model i_srpc_ctrl_model (.i_clock(i_clock), .o_cke(i_cke), .o_cs_n(i_cs_n),
    .o_ras_n(i_ras_n), .o_cas_n(i_cas_n), .o_we_n(i_we_n));
  localparam int SELF_SIM = 4;
  srpc_command_logic #(.SELF_CYCLES(SELF_SIM)) i_srpc_command_logic (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_cke(i_cke), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
    .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_dqm(i_dqm), .i_all_banks_idle(i_all_banks_idle),
    .i_read_burst(i_read_burst), .i_write_burst(i_write_burst),
    .i_auto_precharge(i_auto_precharge), .i_read_latency(i_read_latency),
    .o_internal_clk_en(o_internal_clk_en), .o_buffers_on(o_buffers_on),
    .o_self_refresh(o_self_refresh), .o_refresh_strobe(o_refresh_strobe),
    .o_refresh_row(o_refresh_row), .o_burst_stop(o_burst_stop), .o_read_drain(o_read_drain),
    .o_write_enable(o_write_enable), .o_dq_oe(o_dq_oe));
  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic go(input logic cs_n, input logic [2:0] c, input logic ke);
    i_srpc_ctrl_model.issue(cs_n, c, ke);
  endtask
  task automatic t_refresh;
    go(0, CMD_REFRESH, 1);
    `CHK("row", 13'h1, o_refresh_row)
    repeat (6) go(0, CMD_NOP, 1);
    `CHK("nop strobe", 1'b0, o_refresh_strobe)
    go(1, CMD_REFRESH, 1);
    `CHK("deselect row", 13'h1, o_refresh_row)
    go(0, CMD_REFRESH, 1);
    `CHK("strobe", 1'b1, o_refresh_strobe)
    `CHK("row again", 13'h2, o_refresh_row)
  endtask
  task automatic t_stop;
    for (int l = 2; l <= 3; l++) begin
      i_read_latency = l[1:0];
      i_read_burst = 1;
      go(0, CMD_BURST_STOP, 1);
      i_read_burst = 0;
      `CHK("stop", 1'b1, o_burst_stop)
      repeat (l) begin
        `CHK("drain", 1'b1, o_read_drain)
        @(negedge i_clock);
      end
      `CHK("drain end", 1'b0, o_read_drain)
    end
    i_read_burst = 1;
    i_auto_precharge = 1;
    go(0, CMD_BURST_STOP, 1);
    `CHK("stop ap", 1'b0, o_burst_stop)
    {i_read_burst, i_auto_precharge, i_write_burst} = 3'h1;
    go(0, CMD_BURST_STOP, 1);
    `CHK("stop write", 1'b1, o_burst_stop)
    i_write_burst = 0;
  endtask
  task automatic t_power;
    go(1, CMD_NOP, 0);
    `CHK("pd", 2'h0, {o_internal_clk_en, o_buffers_on})
    go(1, CMD_NOP, 1);
    `CHK("pd exit", 2'h3, {o_internal_clk_en, o_buffers_on})
    {i_read_burst, i_write_burst} = 2'h2;
    go(1, CMD_NOP, 0);
    `CHK("suspend", 2'h1, {o_internal_clk_en, o_buffers_on})
    go(1, CMD_NOP, 1);
    `CHK("resume", 1'b1, o_internal_clk_en)
    i_read_burst = 0;
  endtask
  task automatic t_self;
    logic [ROW_BITS-1:0] r;
    int n;
    r = o_refresh_row;
    n = 0;
    repeat (REFRESH_ROWS) begin
      go(0, CMD_REFRESH, 1);
      repeat (3) go(0, CMD_NOP, 1);
    end
    `CHK("row wrap", r, o_refresh_row)
    go(0, CMD_REFRESH, 0);
    `CHK("self", 1'b1, o_self_refresh)
    repeat (3 * SELF_SIM) begin
      @(negedge i_clock);
      n += o_refresh_strobe;
    end
    `CHK("self count", 3, n)
    `CHK("self rows", r + 13'h3, o_refresh_row)
    go(1, CMD_NOP, 1);
    `CHK("self exit", 1'b0, o_self_refresh)
  endtask
  task automatic t_mask;
    i_write_burst = 1;
    @(negedge i_clock);
    `CHK("write", 1'b1, o_write_enable)
    i_dqm = 1;
    @(negedge i_clock);
    `CHK("masked", 1'b0, o_write_enable)
    {i_write_burst, i_read_burst} = 2'h1;
    @(negedge i_clock);
    `CHK("oe off", 1'b0, o_dq_oe)
    i_dqm = 0;
    @(negedge i_clock);
    `CHK("oe on", 1'b1, o_dq_oe)
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 0;
    t_refresh();
    t_stop();
    t_power();
    t_self();
    t_mask();
    conclude();
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      conclude();
    end
  end
endmodule
bind srpc_command_logic srpc_chk #(.SELF_CYCLES(SELF_CYCLES)) u_chk (.*);
`default_nettype wire
